// ---- design/serial_boot_consts.svh ----
// Purpose: Offsets, field widths, reset values and counts for the serial boot loader.
// Assumes: Included by bare name from the package and the design file.
// Notes:   Widths are fixed; the byte total and ROM fill are plain defaults.
`ifndef SERIAL_BOOT_CONSTS_SVH
`define SERIAL_BOOT_CONSTS_SVH

`define WORD_W            24
`define BYTE_W            8
`define DIRECT_ADDR_W     18
`define PAGE_W            6
`define LAMP_W            4
`define FIFO_DEPTH        16
`define STACK_DEPTH       8
`define STACK_PTR_W       4
`define ROM_DEPTH         16

`define BOOT_BYTE_TOTAL   16'h0180
`define BOOT_LOAD_BASE    18'h00001
`define RUN_START_ADDR    24'h000001
`define RESET_FETCH_ADDR  24'h000000
`define ROM_ALIAS_PAGE    20'h02000
`define ROM_JUMP_OP       6'h2A
`define ROM_JUMP_TARGET   18'h20001
`define ROM_FILL_WORD     24'h000000

`define IO_INT_CTRL       2'h0
`define IO_SERIAL         2'h1
`define IO_ZERO_TX2       2'h2
`define IO_ONE_LAMPS      2'h3
`define CONST_ZERO        24'h000000
`define CONST_ONE         24'h000001
`define INT_CTRL_RESET    24'h000000

`endif

// ---- design/serial_boot_loader_io_bus.sv ----
// Purpose: Serial boot loader, boot ROM, PC redirect, stacks and I/O bus decode.
// Assumes: Received bytes arrive as valid/ready bytes from the command receiver.
// Notes:   Loading is done in hardware; the core fetches the ROM in parallel.
// What this block does
// RQ1: After reset fetch starts at location zero, decoded to the boot ROM.
// RQ2: Boot ROM holds sixteen words of loader program; here word zero is the jump and the other fifteen are ROM_FILL_WORD.
// RQ3: ROM word zero is an unconditional jump to address 20001 hex.
// RQ4: Loader takes a fixed byte count; host sends exactly that many.
// RQ5: Three bytes form one 24-bit word, first byte most significant.
// RQ6: Words are written to SRAM consecutively from address one.
// RQ7: After the full count, control passes to SRAM address one.
// RQ8: Byte counter and three-state position counter; exit only at total.
// RQ9: Core words are 24 bits with separate data and return stacks.
// RQ10: Direct addressing covers one page of 256K 24-bit words.
// RQ11: A full 24-bit address popped by return reaches any page.
// RQ12: I/O read at location zero returns interrupt control and status.
// RQ13: I/O write at location zero updates interrupt control and status.
// RQ14: I/O read at location one returns the last received byte.
// RQ15: I/O read at two returns zero, at three returns one.
// RQ16: I/O write at location one loads the first transmitter.
// RQ17: I/O write at location two loads the second transmitter.
// RQ18: I/O write at location three drives lamps from low four bits.
// RQ19: First link is two-way: boot and commands in, responses out.
// RQ20: Second link carries data only from device to host.
// RQ21: The command port also receives the boot code.
`timescale 1ns/1ps
`include "serial_boot_consts.svh"

module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic             inValid,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  inReady,
    output logic                  outValid,
    output logic [WIDTH-1:0]      outData,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_q;
    logic [AW-1:0]    rdPtr_q;
    logic [AW:0]      count_q;
    logic [AW:0]      count_d;
    logic             inReady_q;
    logic             push;
    logic             pop;

    assign outValid = (count_q != '0);
    assign outData  = mem[rdPtr_q];
    assign inReady  = inReady_q;
    assign push     = inValid && inReady_q;
    assign pop      = outValid && outReady;

    always_comb begin
        count_d = count_q;
        if (push && !pop) begin
            count_d = count_q + (AW+1)'(1);
        end else if (pop && !push) begin
            count_d = count_q - (AW+1)'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
    end

    // Ready is registered so the source never sees a combinational path
    always_ff @(posedge core_clk) begin
        if (reset) begin
            wrPtr_q   <= '0;
            rdPtr_q   <= '0;
            count_q   <= '0;
            inReady_q <= 1'b0;
        end else begin
            if (push) begin
                wrPtr_q <= wrPtr_q + AW'(1);
            end
            if (pop) begin
                rdPtr_q <= rdPtr_q + AW'(1);
            end
            count_q   <= count_d;
            inReady_q <= (count_d != (AW+1)'(DEPTH));
        end
    end
endmodule // byte_fifo

module serial_boot_loader_io_bus
    import serial_boot_pkg::*;
(
    input  wire logic                      core_clk,
    input  wire logic                      reset,
    input  wire logic                      rxValid,
    input  wire logic [`BYTE_W-1:0]        rxData,
    output logic                           rxReady,
    output logic                           sramWrEn,
    output logic [`DIRECT_ADDR_W-1:0]      sramAddr,
    output logic [`WORD_W-1:0]             sramWrData,
    input  wire logic                      sramReady,
    output logic                           bootMode,
    input  wire logic                      fetchReq,
    input  wire logic [`WORD_W-1:0]        fetchAddr,
    output logic                           fetchFromRom,
    output logic [`WORD_W-1:0]             fetchData,
    output logic                           pcLoad,
    output logic [`WORD_W-1:0]             pcTarget,
    input  wire logic                      jumpExec,
    input  wire logic [`DIRECT_ADDR_W-1:0] jumpAddr,
    input  wire logic                      retPush,
    input  wire logic [`WORD_W-1:0]        retPushData,
    input  wire logic                      retExec,
    input  wire logic                      dataPush,
    input  wire logic                      dataPop,
    input  wire logic [`WORD_W-1:0]        dataPushData,
    output logic [`WORD_W-1:0]             dataTop,
    output logic [`STACK_PTR_W-1:0]        dataDepth,
    input  wire logic                      ioRd,
    input  wire logic                      ioWr,
    input  wire logic [1:0]                ioAddr,
    input  wire logic [`WORD_W-1:0]        ioWrData,
    output logic [`WORD_W-1:0]             ioRdData,
    output logic [`WORD_W-1:0]             intCtrl,
    output logic                           cmdTxValid,
    output logic [`BYTE_W-1:0]             cmdTxData,
    output logic                           dataTxValid,
    output logic [`BYTE_W-1:0]             dataTxData,
    output logic [`LAMP_W-1:0]             lamps
);
    // ROM image: word zero jumps into the alias page, rest is ROM_FILL_WORD
    localparam word_t ROM_IMAGE [`ROM_DEPTH] = '{
        {`ROM_JUMP_OP, `ROM_JUMP_TARGET}, `ROM_FILL_WORD, `ROM_FILL_WORD, `ROM_FILL_WORD,
        `ROM_FILL_WORD, `ROM_FILL_WORD, `ROM_FILL_WORD, `ROM_FILL_WORD,
        `ROM_FILL_WORD, `ROM_FILL_WORD, `ROM_FILL_WORD, `ROM_FILL_WORD,
        `ROM_FILL_WORD, `ROM_FILL_WORD, `ROM_FILL_WORD, `ROM_FILL_WORD};

    loadState_t                    ldState_q;
    logic [15:0]                   byteCnt_q;
    logic [1:0]                    bytePos_q;
    logic [15:0]                   wordHold_q;
    logic                          sramWrEn_q;
    logic [`DIRECT_ADDR_W-1:0]     sramAddr_q;
    word_t                         sramWrData_q;
    logic                          fifoOutValid;
    logic [`BYTE_W-1:0]            fifoOutData;
    logic                          fifoInReady;
    logic                          fifoPop;
    logic                          canTake;
    logic                          issueWrite;
    logic                          finishBoot;
    logic                          fetchFromRom_q;
    word_t                         fetchData_q;
    logic                          pcLoad_q;
    word_t                         pcTarget_q;
    logic [`PAGE_W-1:0]            page_q;
    word_t                         retMem [`STACK_DEPTH];
    logic [`STACK_PTR_W-1:0]       retPtr_q;
    word_t                         dataMem [`STACK_DEPTH];
    logic [`STACK_PTR_W-1:0]       dataPtr_q;
    word_t                         dataTop_q;
    logic                          retTake;
    word_t                         retTop;
    word_t                         ioRdData_q;
    word_t                         intCtrl_q;
    logic [`BYTE_W-1:0]            rxLast_q;
    logic                          cmdTxValid_q;
    logic [`BYTE_W-1:0]            cmdTxData_q;
    logic                          dataTxValid_q;
    logic [`BYTE_W-1:0]            dataTxData_q;
    logic [`LAMP_W-1:0]            lamps_q;
    logic                          bootMode_q;

    // Boot bytes and later commands share the one receive path
    byte_fifo #(
        .WIDTH (`BYTE_W),
        .DEPTH (`FIFO_DEPTH)
    ) u_rx_fifo (
        .core_clk (core_clk),
        .reset    (reset),
        .inValid  (rxValid),
        .inData   (rxData),
        .inReady  (fifoInReady),
        .outValid (fifoOutValid),
        .outData  (fifoOutData),
        .outReady (canTake)
    ); // see RQ21

    // A pending SRAM write stalls the drain, so back-pressure reaches the host
    assign canTake    = (ldState_q == LD_RUN) ||
                        ((ldState_q == LD_LOAD) && !(sramWrEn_q && !sramReady));
    assign fifoPop    = fifoOutValid && canTake;
    assign issueWrite = fifoPop && (ldState_q == LD_LOAD) && (bytePos_q == 2'd2); // see RQ5
    assign finishBoot = (ldState_q == LD_FLUSH) && (!sramWrEn_q || sramReady);
    assign retTake    = retExec && (retPtr_q != '0);
    assign retTop     = retMem[3'(retPtr_q - `STACK_PTR_W'(1))];

    always_ff @(posedge core_clk) begin
        if (reset) begin
            ldState_q <= LD_LOAD;
            byteCnt_q <= '0;
            bytePos_q <= '0;
        end else begin
            case (ldState_q)
                LD_LOAD: begin
                    if (fifoPop) begin
                        byteCnt_q <= byteCnt_q + 16'h0001; // see RQ8
                        bytePos_q <= (bytePos_q == 2'd2) ? 2'd0 : bytePos_q + 2'd1;
                        if (byteCnt_q == `BOOT_BYTE_TOTAL - 16'h0001) begin
                            ldState_q <= LD_FLUSH; // see RQ4
                        end
                    end
                end
                LD_FLUSH: begin
                    if (finishBoot) begin
                        ldState_q <= LD_RUN;
                    end
                end
                LD_RUN: begin
                    ldState_q <= LD_RUN;
                end
                default: begin
                    ldState_q <= LD_LOAD;
                end
            endcase
        end
    end

    // Word assembly and SRAM write port
    always_ff @(posedge core_clk) begin
        if (reset) begin
            wordHold_q   <= '0;
            sramWrEn_q   <= 1'b0;
            sramAddr_q   <= `BOOT_LOAD_BASE; // see RQ6
            sramWrData_q <= '0;
        end else begin
            if (fifoPop && ldState_q == LD_LOAD) begin
                wordHold_q <= {wordHold_q[7:0], fifoOutData};
            end
            if (sramWrEn_q && sramReady) begin
                sramAddr_q <= sramAddr_q + `DIRECT_ADDR_W'(1); // see RQ6
            end
            if (issueWrite) begin
                sramWrEn_q   <= 1'b1;
                sramWrData_q <= {wordHold_q, fifoOutData}; // see RQ5
            end else if (sramReady) begin
                sramWrEn_q <= 1'b0;
            end
        end
    end

    // Own flop so the core never sees a state decode glitch
    always_ff @(posedge core_clk) begin
        if (reset) begin
            bootMode_q <= 1'b1;
        end else if (finishBoot) begin
            bootMode_q <= 1'b0; // see RQ7
        end
    end

    // Boot ROM answer, visible only while booting
    always_ff @(posedge core_clk) begin
        if (reset) begin
            fetchFromRom_q <= 1'b0;
            fetchData_q    <= '0;
        end else begin
            fetchFromRom_q <= fetchReq && (ldState_q != LD_RUN) && romHit(fetchAddr); // see RQ1
            fetchData_q    <= ROM_IMAGE[fetchAddr[3:0]]; // see RQ2
        end
    end

    // PC redirect: reset, boot hand-over, full-address return, in-page jump
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pcLoad_q   <= 1'b1;
            pcTarget_q <= `RESET_FETCH_ADDR; // see RQ1
            page_q     <= '0;
        end else begin
            pcLoad_q <= 1'b0;
            if (finishBoot) begin
                pcLoad_q   <= 1'b1;
                pcTarget_q <= `RUN_START_ADDR; // see RQ7
                page_q     <= '0;
            end else if (retTake) begin
                pcLoad_q   <= 1'b1;
                pcTarget_q <= retTop; // see RQ11
                page_q     <= retTop[`WORD_W-1:`DIRECT_ADDR_W];
            end else if (jumpExec) begin
                pcLoad_q   <= 1'b1;
                pcTarget_q <= {page_q, jumpAddr}; // see RQ10
            end
        end
    end

    // Return stack; a return in the same cycle beats a push
    always_ff @(posedge core_clk) begin
        if (reset) begin
            retPtr_q <= '0;
        end else if (retTake) begin
            retPtr_q <= retPtr_q - `STACK_PTR_W'(1);
        end else if (retPush && retPtr_q != `STACK_PTR_W'(`STACK_DEPTH)) begin
            retMem[retPtr_q[2:0]] <= retPushData; // see RQ9
            retPtr_q              <= retPtr_q + `STACK_PTR_W'(1);
        end
    end

    // Data stack; overflow pushes and underflow pops are dropped
    always_ff @(posedge core_clk) begin
        if (reset) begin
            dataPtr_q <= '0;
            dataTop_q <= '0;
        end else if (dataPush && dataPtr_q != `STACK_PTR_W'(`STACK_DEPTH)) begin
            dataMem[dataPtr_q[2:0]] <= dataPushData; // see RQ9
            dataPtr_q               <= dataPtr_q + `STACK_PTR_W'(1);
            dataTop_q               <= dataPushData;
        end else if (dataPop && dataPtr_q != '0) begin
            dataPtr_q <= dataPtr_q - `STACK_PTR_W'(1);
            dataTop_q <= (dataPtr_q > `STACK_PTR_W'(1)) ?
                         dataMem[3'(dataPtr_q - `STACK_PTR_W'(2))] : '0;
        end
    end

    // I/O bus reads, one cycle behind the strobe
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ioRdData_q <= '0;
        end else if (ioRd) begin
            case (ioAddr)
                `IO_INT_CTRL:  ioRdData_q <= intCtrl_q; // see RQ12
                `IO_SERIAL:    ioRdData_q <= {16'h0000, rxLast_q}; // see RQ14
                `IO_ZERO_TX2:  ioRdData_q <= `CONST_ZERO; // see RQ15
                `IO_ONE_LAMPS: ioRdData_q <= `CONST_ONE; // see RQ15
                default:       ioRdData_q <= `CONST_ZERO;
            endcase
        end
    end

    // Last received byte, caught as it leaves the buffer
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rxLast_q <= '0;
        end else if (fifoPop) begin
            rxLast_q <= fifoOutData; // see RQ14
        end
    end

    // I/O bus writes; transmit strobes last one cycle
    always_ff @(posedge core_clk) begin
        if (reset) begin
            intCtrl_q     <= `INT_CTRL_RESET;
            cmdTxValid_q  <= 1'b0;
            cmdTxData_q   <= '0;
            dataTxValid_q <= 1'b0;
            dataTxData_q  <= '0;
            lamps_q       <= '0;
        end else begin
            cmdTxValid_q  <= 1'b0;
            dataTxValid_q <= 1'b0;
            if (ioWr) begin
                case (ioAddr)
                    `IO_INT_CTRL: begin
                        intCtrl_q <= ioWrData; // see RQ13
                    end
                    `IO_SERIAL: begin
                        cmdTxValid_q <= 1'b1; // see RQ16 RQ19
                        cmdTxData_q  <= ioWrData[`BYTE_W-1:0];
                    end
                    `IO_ZERO_TX2: begin
                        dataTxValid_q <= 1'b1; // see RQ17 RQ20
                        dataTxData_q  <= ioWrData[`BYTE_W-1:0];
                    end
                    `IO_ONE_LAMPS: begin
                        lamps_q <= ioWrData[`LAMP_W-1:0]; // see RQ18
                    end
                    default: begin
                        lamps_q <= lamps_q;
                    end
                endcase
            end
        end
    end

    assign rxReady      = fifoInReady;
    assign sramWrEn     = sramWrEn_q;
    assign sramAddr     = sramAddr_q;
    assign sramWrData   = sramWrData_q;
    assign bootMode     = bootMode_q;
    assign fetchFromRom = fetchFromRom_q;
    assign fetchData    = fetchData_q;
    assign pcLoad       = pcLoad_q;
    assign pcTarget     = pcTarget_q;
    assign dataTop      = dataTop_q;
    assign dataDepth    = dataPtr_q;
    assign ioRdData     = ioRdData_q;
    assign intCtrl      = intCtrl_q;
    assign cmdTxValid   = cmdTxValid_q;
    assign cmdTxData    = cmdTxData_q;
    assign dataTxValid  = dataTxValid_q;
    assign dataTxData   = dataTxData_q;
    assign lamps        = lamps_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    reset_fetch_zero_a: assert property ($past(reset) |-> pcLoad && pcTarget == `RESET_FETCH_ADDR) // see RQ1
        else $error("fetch does not restart at location zero");
    rom_jump_word_a: assert property (fetchReq && bootMode && fetchAddr == `RESET_FETCH_ADDR // see RQ3
        |=> fetchFromRom && fetchData == {`ROM_JUMP_OP, `ROM_JUMP_TARGET})
        else $error("location zero is not the jump into the alias page");
    rom_alias_page_a: assert property (fetchReq && bootMode && romHit(fetchAddr) |=> fetchFromRom) // see RQ2
        else $error("boot ROM word not selected");
    byte_pack_a: assert property (issueWrite // see RQ5
        |=> sramWrEn && sramWrData == {$past(wordHold_q), $past(fifoOutData)})
        else $error("packed word has wrong byte order");
    first_word_addr_a: assert property (sramWrEn && bootMode && byteCnt_q < 16'h0006 // see RQ6
        |-> sramAddr == `BOOT_LOAD_BASE)
        else $error("first boot word not at address one");
    run_handover_a: assert property (finishBoot // see RQ7
        |=> pcLoad && pcTarget == `RUN_START_ADDR && !bootMode)
        else $error("boot end does not jump to address one");
    count_exit_a: assert property (!bootMode |-> byteCnt_q == `BOOT_BYTE_TOTAL) // see RQ8
        else $error("boot left before the full byte count");
    return_page_a: assert property (retTake && !finishBoot |=> pcLoad && pcTarget == $past(retTop)) // see RQ11
        else $error("return does not load the full address");
    jump_in_page_a: assert property (jumpExec && !retTake && !finishBoot // see RQ10
        |=> pcTarget == {$past(page_q), $past(jumpAddr)})
        else $error("direct jump left the current page");
    data_push_a: assert property (dataPush && dataDepth < `STACK_PTR_W'(`STACK_DEPTH) // see RQ9
        |=> dataTop == $past(dataPushData) && dataDepth == $past(dataDepth) + `STACK_PTR_W'(1))
        else $error("data stack push lost");
    io_constants_a: assert property (ioRd && ioAddr[1] // see RQ15
        |=> ioRdData == (($past(ioAddr) == `IO_ONE_LAMPS) ? `CONST_ONE : `CONST_ZERO))
        else $error("constant read locations wrong");
    lamp_write_a: assert property (ioWr && ioAddr == `IO_ONE_LAMPS // see RQ18
        |=> lamps == $past(ioWrData[`LAMP_W-1:0]) ##1 !cmdTxValid || $past(ioWr))
        else $error("lamps not taken from low bits");
    tx_route_a: assert property (ioWr && ioAddr == `IO_SERIAL |=> cmdTxValid && !dataTxValid) // see RQ16
        else $error("write at location one reached wrong transmitter");

    boot_done_c: cover property (finishBoot ##1 !bootMode);
    fifo_full_c: cover property (!rxReady ##1 rxReady);
    return_far_c: cover property (retTake && retTop[`WORD_W-1:`DIRECT_ADDR_W] != '0);
    lamp_write_c: cover property (ioWr && ioAddr == `IO_ONE_LAMPS);
endmodule // serial_boot_loader_io_bus

// ---- design/serial_boot_pkg.sv ----
// Purpose: Types and shared decode helpers for the serial boot loader.
// Assumes: Constants come from the header.
// Notes:   None.
package serial_boot_pkg;
`include "serial_boot_consts.svh"

    typedef enum logic [1:0] {
        LD_LOAD  = 2'b00,
        LD_FLUSH = 2'b01,
        LD_RUN   = 2'b10
    } loadState_t;

    typedef logic [`WORD_W-1:0] word_t;

    // Location zero and the alias page both reach the boot ROM
    function automatic logic romHit(input word_t addr);
        romHit = (addr == `RESET_FETCH_ADDR) || (addr[`WORD_W-1:4] == `ROM_ALIAS_PAGE);
    endfunction

endpackage

// ---- sim/host_model.sv ----
// Purpose: Host side of the command link, streaming the boot image byte by byte.
// Assumes: Byte i of the image is i*5+1, truncated to eight bits.
// Notes:   Holds each byte until taken; released data line shows the inverse.
`timescale 1ns/1ps

module host_model #(
    parameter int TOTAL = 384
) (
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic       go,
    input  wire logic       rxReady,
    output logic            rxValid,
    output logic [7:0]      rxData,
    output logic            done
);
    int n;

    assign done = (n == TOTAL);

    // Boot code goes in over the command port; exactly TOTAL bytes, no more
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rxValid <= 1'b0;
            rxData  <= 8'h00;
            n       <= 0;
        end else if (rxValid && rxReady) begin
            n       <= n + 1;
            rxValid <= (n + 1 < TOTAL);
            rxData  <= (n + 1 < TOTAL) ? 8'((n + 1) * 5 + 1) : ~rxData;
        end else if (go && !rxValid && n < TOTAL) begin
            rxValid <= 1'b1;
            rxData  <= 8'(n * 5 + 1);
        end
    end
endmodule // host_model

// ---- sim/tb.sv ----
// Purpose: Bench for boot loading, ROM decode, stacks and I/O bus.
// Assumes: Design port names match the bench signal names.
// Notes:   SRAM is modelled here, stalling every other cycle.
`timescale 1ns/1ps
`include "serial_boot_consts.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errTotal++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end

module tb;
    import serial_boot_pkg::*;
    logic        core_clk, rxValid, rxReady, sramWrEn, bootMode, fetchFromRom, pcLoad, done;
    logic        reset = 1, go = 0, stall = 0, sramReady = 0, cmdTxValid, dataTxValid;
    logic        fetchReq = 0, jumpExec = 0, retPush = 0, retExec = 0, dataPush = 0;
    logic        dataPop = 0, ioRd = 0, ioWr = 0;
    logic [7:0]  rxData, cmdTxData, dataTxData;
    logic [1:0]  ioAddr = 0;
    logic [17:0] sramAddr, jumpAddr = 0;
    logic [3:0]  dataDepth, lamps;
    word_t       fetchAddr = 0, retPushData = 0, dataPushData = 0, ioWrData = 0;
    word_t       sramWrData, fetchData, pcTarget, dataTop, ioRdData, intCtrl;
    int          errTotal = 0, comparisons = 0, cyc = 0, words = 0;

    serial_boot_loader_io_bus serial_boot_loader_io_bus_inst (.*);
    host_model host_model_inst (.core_clk(core_clk), .reset(reset), .go(go),
        .rxReady(rxReady), .rxValid(rxValid), .rxData(rxData), .done(done));

    function automatic logic [7:0] bv(input int i);
        return 8'(i * 5 + 1);
    endfunction

    task automatic close_out;
        $display("errors %0d comparisons %0d", errTotal, comparisons);
        if (errTotal == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic io(input logic wr, input logic [1:0] a, input word_t d);
        @(posedge core_clk);
        ioRd <= !wr;
        ioWr <= wr;
        ioAddr <= a;
        ioWrData <= d;
        @(posedge core_clk);
        {ioRd, ioWr} <= 2'b00;
        #1;
    endtask

    task automatic fetch(input word_t a);
        @(posedge core_clk);
        fetchReq <= 1'b1;
        fetchAddr <= a;
        @(posedge core_clk);
        fetchReq <= 1'b0;
        #1;
    endtask

    task automatic ctl(input logic [4:0] p, input word_t d);
        @(posedge core_clk);
        {jumpExec, retPush, retExec, dataPush, dataPop} <= p;
        retPushData <= d;
        dataPushData <= d;
        jumpAddr <= d[17:0];
        @(posedge core_clk);
        {jumpExec, retPush, retExec, dataPush, dataPop} <= 5'h00;
        #1;
    endtask

    initial begin
        core_clk = 0;
        forever #5 core_clk = ~core_clk;
    end

    // SRAM side; stalls when asked and on odd cycles
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        sramReady <= !stall && !cyc[0];
        if (!reset && sramWrEn && sramReady) begin
            `CHK(sramAddr, 18'(words + 1))
            `CHK(sramWrData, {bv(3 * words), bv(3 * words + 1), bv(3 * words + 2)})
            `CHK(bootMode, 1'b1)
            words++;
        end
        if (cyc == 20000) begin
            errTotal++;
            close_out;
        end
    end

    initial begin
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        fetch(24'h000000);
        `CHK(fetchFromRom, 1'b1)
        `CHK(fetchData, {`ROM_JUMP_OP, 18'h20001})
        fetch(24'h02000F);
        `CHK(fetchFromRom, 1'b1)
        `CHK(fetchData, 24'h000000)
        fetch(24'h020010);
        `CHK(fetchFromRom, 1'b0)
        io(1'b1, 2'h0, 24'h00A5C3);
        `CHK(intCtrl, 24'h00A5C3)
        io(1'b0, 2'h0, 24'h000000);
        `CHK(ioRdData, 24'h00A5C3)
        io(1'b0, 2'h2, 24'h000000);
        `CHK(ioRdData, 24'h000000)
        io(1'b0, 2'h3, 24'h000000);
        `CHK(ioRdData, 24'h000001)
        io(1'b1, 2'h1, 24'hFFFF3C);
        `CHK({cmdTxValid, cmdTxData}, 9'h13C)
        io(1'b1, 2'h2, 24'h0000E7);
        `CHK({cmdTxValid, dataTxValid, dataTxData}, 10'h1E7)
        io(1'b1, 2'h3, 24'h00005A);
        `CHK(lamps, 4'hA)
        ctl(5'b00010, 24'h123456);
        ctl(5'b00010, 24'hABCDEF);
        `CHK({dataTop, dataDepth}, {24'hABCDEF, 4'h2})
        ctl(5'b00001, 24'h000000);
        `CHK({dataTop, dataDepth}, {24'h123456, 4'h1})
        ctl(5'b01000, 24'h450123);
        ctl(5'b00100, 24'h000000);
        `CHK({pcLoad, pcTarget}, {1'b1, 24'h450123})
        ctl(5'b10000, 24'h000ABC);
        `CHK({pcLoad, pcTarget}, {1'b1, 24'h440ABC})
        // Stalled SRAM backs up the buffer until it refuses
        @(posedge core_clk);
        go <= 1'b1;
        stall <= 1'b1;
        repeat (40) @(posedge core_clk);
        stall <= 1'b0;
        #1;
        `CHK({rxReady, rxValid, bootMode}, 3'b011)
        repeat (4000) begin
            @(posedge core_clk);
            #1;
            if (bootMode === 1'b0) break;
        end
        `CHK({bootMode, pcLoad, pcTarget}, {2'b01, 24'h000001})
        `CHK({words, done}, {32'd128, 1'b1})
        fetch(24'h000000);
        `CHK(fetchFromRom, 1'b0)
        io(1'b0, 2'h1, 24'h000000);
        `CHK(ioRdData, {16'h0000, bv(383)})
        close_out;
    end
endmodule // tb
